// File: rtl/lcsl_consts.svh
// timing counts and field positions for the led channel shift latch
`ifndef LCSL_CONSTS_SVH
`define LCSL_CONSTS_SVH
`define LCSL_WORD_BITS      3
`define LCSL_BIT_LOW        0
`define LCSL_BIT_MID        1
`define LCSL_BIT_HIGH       2
`define LCSL_SYS_PERIOD_PS  5000
`define LCSL_SCLK_HALF_NS   30
`define LCSL_SCLK_HALF_CYC  ((`LCSL_SCLK_HALF_NS * 1000 + `LCSL_SYS_PERIOD_PS - 1) / `LCSL_SYS_PERIOD_PS)
`define LCSL_LATCH_HOLD_NS  25
`define LCSL_LATCH_HOLD_CYC ((`LCSL_LATCH_HOLD_NS * 1000 + `LCSL_SYS_PERIOD_PS - 1) / `LCSL_SYS_PERIOD_PS)
`define LCSL_ADDR_CTRL      4'h0
`define LCSL_ADDR_WORD      4'h1
`define LCSL_ADDR_STATUS    4'h2
`define LCSL_ADDR_IRQ_STAT  4'h3
`define LCSL_ADDR_IRQ_MASK  4'h4
`define LCSL_ADDR_WORDS     4'h5
`define LCSL_CTRL_START     0
`define LCSL_CTRL_GATE_N    1
`define LCSL_CTRL_HOLD_OPEN 2
`define LCSL_IRQ_DONE       0
`define LCSL_IRQ_THERMAL    1
`endif

// File: rtl/lcsl_pkg.sv
// types shared by both ends of the led channel shift latch link
package lcsl_pkg;
  typedef logic [2:0] lcsl_word_t;
  typedef enum logic [2:0] {
    LCSL_IDLE,
    LCSL_SETUP,
    LCSL_HIGH,
    LCSL_LOW,
    LCSL_LATCH,
    LCSL_DONE
  } lcsl_state_t;
endpackage : lcsl_pkg

// File: rtl/lcsl_link_if.sv
// serial link joining the host end to the driver end
`timescale 1ns/1ps
`default_nettype none
interface lcsl_link_if;
  logic sclk;
  logic sdata_in;
  logic sdata_out;
  logic latch_load;
  logic gate_n;
  modport host (
    output sclk,
    output sdata_in,
    input  sdata_out,
    output latch_load,
    output gate_n
  );
  modport device (
    input  sclk,
    input  sdata_in,
    output sdata_out,
    input  latch_load,
    input  gate_n
  );
endinterface : lcsl_link_if
`default_nettype wire

// File: rtl/lcsl_driver.sv
// driver end: shift register, output latch, gate, dimming variant, thermal shutdown
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lcsl_consts.svh"
// Functional notes
// - shift data in on clock rising edge
// - word is three bits, low mid high
// - high bit shifted first, low bit last
// - host keeps data settled at edge
// - serial out shows last shift stage
// - input reaches serial out after three edges
// - chained drivers share clock and latch
// - latch follows shift register while load high
// - latch holds on load falling edge
// - gate high turns all channels off (the parallel variant ignores the gate)
// - gate low channels follow latch bits
// - shifting independent of gate level
// - dim inputs switch own channel directly
// - overheat turns all channels off
// - leave shutdown only after cooling hysteresis
// - dim inputs kept at low rate
// - host keeps clock slow when transparent
module lcsl_driver #(
  parameter bit PARALLEL_VARIANT = 1'b0
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  lcsl_link_if.device     link,
  input  wire logic       i_channel1_dim_in,
  input  wire logic       i_channel2_dim_in,
  input  wire logic       i_channel3_dim_in,
  input  wire logic       i_temp_over,
  input  wire logic       i_temp_cool,
  output logic            o_channel1_sink,
  output logic            o_channel2_sink,
  output logic            o_channel3_sink,
  output logic            o_thermal_off
);
  localparam int W = `LCSL_WORD_BITS;
  // agreed levels of every asynchronous input
  logic sclk_q;
  logic din_q;
  logic load_q;
  logic gate_q;
  logic d1_q;
  logic d2_q;
  logic d3_q;
  logic hot_q;
  logic cool_q;
  lcsl_sync i_sync_sclk (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (link.sclk),
    .o_level   (sclk_q)
  );
  lcsl_sync i_sync_din (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (link.sdata_in),
    .o_level   (din_q)
  );
  lcsl_sync i_sync_load (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (link.latch_load),
    .o_level   (load_q)
  );
  lcsl_sync #(.RESET_LEVEL(1'b1)) i_sync_gate (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (link.gate_n),
    .o_level   (gate_q)
  );
  lcsl_sync i_sync_d1 (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (i_channel1_dim_in),
    .o_level   (d1_q)
  );
  lcsl_sync i_sync_d2 (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (i_channel2_dim_in),
    .o_level   (d2_q)
  );
  lcsl_sync i_sync_d3 (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (i_channel3_dim_in),
    .o_level   (d3_q)
  );
  lcsl_sync i_sync_hot (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (i_temp_over),
    .o_level   (hot_q)
  );
  lcsl_sync i_sync_cool (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_async   (i_temp_cool),
    .o_level   (cool_q)
  );
  logic sclk_prev;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) sclk_prev <= 1'b0;
    else sclk_prev <= sclk_q;
  end
  wire sclk_rise = sclk_q && !sclk_prev;
  // din_q lags sclk_q equally, so the level sampled is the one at the edge
  lcsl_pkg::lcsl_word_t shift_reg;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_reg <= 3'h0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[W-2:0], din_q};
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) link.sdata_out <= 1'b0;
    else link.sdata_out <= shift_reg[W-1];
  end
  // transparent while load high, frozen from its fall onward
  lcsl_pkg::lcsl_word_t out_latch;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) out_latch <= 3'h0;
    else if (load_q) out_latch <= shift_reg;
  end
  // thermal shutdown with hysteresis: set by overheat, cleared by cool flag
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) o_thermal_off <= 1'b0;
    else if (hot_q) o_thermal_off <= 1'b1;
    else if (cool_q) o_thermal_off <= 1'b0;
  end
  // shutdown acts at once, before the registered flag follows
  wire off_now = o_thermal_off || hot_q;
  lcsl_channel #(.PARALLEL_VARIANT(PARALLEL_VARIANT)) i_chan1 (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_dim       (d1_q),
    .i_latch_bit (out_latch[`LCSL_BIT_LOW]),
    .i_gate_n    (gate_q),
    .i_off       (off_now),
    .o_sink      (o_channel1_sink)
  );
  lcsl_channel #(.PARALLEL_VARIANT(PARALLEL_VARIANT)) i_chan2 (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_dim       (d2_q),
    .i_latch_bit (out_latch[`LCSL_BIT_MID]),
    .i_gate_n    (gate_q),
    .i_off       (off_now),
    .o_sink      (o_channel2_sink)
  );
  lcsl_channel #(.PARALLEL_VARIANT(PARALLEL_VARIANT)) i_chan3 (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_dim       (d3_q),
    .i_latch_bit (out_latch[`LCSL_BIT_HIGH]),
    .i_gate_n    (gate_q),
    .i_off       (off_now),
    .o_sink      (o_channel3_sink)
  );
endmodule : lcsl_driver

// three-flop sampler for one input from outside the clock domain
module lcsl_sync #(
  parameter bit RESET_LEVEL = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_async,
  output logic      o_level
);
  logic [2:0] stages;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      stages <= {3{RESET_LEVEL}};
    end else begin
      stages <= {stages[1:0], i_async};
    end
  end
  // a change counts once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= RESET_LEVEL;
    end else if (stages[1] == stages[2]) begin
      o_level <= stages[2];
    end
  end
endmodule : lcsl_sync

// one sink output: latch bit masked by gate and shutdown, or dimming bit masked by shutdown only
module lcsl_channel #(
  parameter bit PARALLEL_VARIANT = 1'b0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_dim,
  input  wire logic i_latch_bit,
  input  wire logic i_gate_n,
  input  wire logic i_off,
  output logic      o_sink
);
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sink <= 1'b0;
    end else if (i_off) begin
      o_sink <= 1'b0;
    end else if (PARALLEL_VARIANT) begin
      o_sink <= i_dim;
    end else if (i_gate_n) begin
      o_sink <= 1'b0;
    end else begin
      o_sink <= i_latch_bit;
    end
  end
endmodule : lcsl_channel
`default_nettype wire

// File: rtl/lcsl_host.sv
// host end: register port, serial word sender, latch pulse, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "lcsl_consts.svh"
module lcsl_host #(
  parameter int MAX_DEVICES = 4
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  lcsl_link_if.host        link,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_thermal_off,
  output logic      [31:0] o_rdata,
  output logic             o_irq
);
  localparam int W  = `LCSL_WORD_BITS;
  localparam int TB = W * MAX_DEVICES;
  localparam int HC = `LCSL_SCLK_HALF_CYC;
  localparam int LC = `LCSL_LATCH_HOLD_CYC;
  localparam int CW = $clog2(TB + HC + LC + 2);
  lcsl_pkg::lcsl_state_t state;
  logic [TB-1:0] words;
  logic [TB-1:0] sh;
  logic [7:0]    ndev;
  logic          gate_n_reg, hold_open;
  logic [1:0]    irq_stat, irq_mask;
  logic [CW-1:0] tmr, bits_left;
  logic [2:0]    s_th;
  logic          th_q, th_prev;
  wire wr_ctrl = i_wr && i_addr == `LCSL_ADDR_CTRL;
  wire start = wr_ctrl && i_wdata[`LCSL_CTRL_START] && state == lcsl_pkg::LCSL_IDLE;
  // registers written by software
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      gate_n_reg <= 1'b1;
      hold_open  <= 1'b0;
      words      <= '0;
      ndev       <= 8'h01;
      irq_mask   <= 2'h0;
    end else if (i_wr) begin
      case (i_addr)
        `LCSL_ADDR_CTRL: begin
          gate_n_reg <= i_wdata[`LCSL_CTRL_GATE_N];
          hold_open  <= i_wdata[`LCSL_CTRL_HOLD_OPEN];
        end
        `LCSL_ADDR_WORD:     words    <= i_wdata[TB-1:0];
        `LCSL_ADDR_IRQ_MASK: irq_mask <= i_wdata[1:0];
        `LCSL_ADDR_WORDS:    ndev     <= i_wdata[7:0];
        default: ;
      endcase
    end
  end
  // thermal flag from the driver is asynchronous here
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_th    <= 3'h0;
      th_q    <= 1'b0;
      th_prev <= 1'b0;
    end else begin
      s_th <= {s_th[1:0], i_thermal_off};
      if (s_th[1] == s_th[2]) th_q <= s_th[2];
      th_prev <= th_q;
    end
  end
  // sticky events, set wins over write-one-to-clear
  wire ev_done = state == lcsl_pkg::LCSL_DONE;
  wire ev_th   = th_q && !th_prev;
  wire [1:0] clr = (i_wr && i_addr == `LCSL_ADDR_IRQ_STAT) ? i_wdata[1:0] : 2'h0;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) irq_stat <= 2'h0;
    else irq_stat <= (irq_stat & ~clr) | {ev_th, ev_done};
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) o_irq <= 1'b0;
    else o_irq <= |(irq_stat & irq_mask);
  end
  // serial sender: high bit first, three bits per chained driver
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state          <= lcsl_pkg::LCSL_IDLE;
      sh             <= '0;
      tmr            <= '0;
      bits_left      <= '0;
      link.sclk      <= 1'b0;
      link.sdata_in  <= 1'b0;
      link.latch_load <= 1'b0;
    end else begin
      case (state)
        lcsl_pkg::LCSL_IDLE: begin
          link.latch_load <= hold_open;
          if (start) begin
            sh        <= words << (TB - W * int'(ndev));
            bits_left <= CW'(W * int'(ndev));
            state     <= lcsl_pkg::LCSL_SETUP;
          end
        end
        lcsl_pkg::LCSL_SETUP: begin
          link.sdata_in <= sh[TB-1];
          sh            <= sh << 1;
          tmr           <= CW'(HC);
          state         <= lcsl_pkg::LCSL_LOW;
        end
        lcsl_pkg::LCSL_LOW: begin
          if (tmr == 0) begin
            link.sclk <= 1'b1;
            tmr       <= CW'(HC);
            bits_left <= bits_left - 1'b1;
            state     <= lcsl_pkg::LCSL_HIGH;
          end else tmr <= tmr - 1'b1;
        end
        lcsl_pkg::LCSL_HIGH: begin
          if (tmr == 0) begin
            link.sclk <= 1'b0;
            if (bits_left == 0) begin
              tmr             <= CW'(LC);
              link.latch_load <= 1'b1;
              state           <= lcsl_pkg::LCSL_LATCH;
            end else state <= lcsl_pkg::LCSL_SETUP;
          end else tmr <= tmr - 1'b1;
        end
        lcsl_pkg::LCSL_LATCH: begin
          if (tmr == 0) begin
            link.latch_load <= hold_open;
            state           <= lcsl_pkg::LCSL_DONE;
          end else tmr <= tmr - 1'b1;
        end
        lcsl_pkg::LCSL_DONE: state <= lcsl_pkg::LCSL_IDLE;
        default: state <= lcsl_pkg::LCSL_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) link.gate_n <= 1'b1;
    else link.gate_n <= gate_n_reg;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) o_rdata <= 32'h0000_0000;
    else if (i_rd) begin
      case (i_addr)
        `LCSL_ADDR_CTRL:     o_rdata <= {29'h0, hold_open, gate_n_reg, 1'b0};
        `LCSL_ADDR_WORD:     o_rdata <= 32'(words);
        `LCSL_ADDR_STATUS:   o_rdata <= {30'h0, th_q, state != lcsl_pkg::LCSL_IDLE};
        `LCSL_ADDR_IRQ_STAT: o_rdata <= {30'h0, irq_stat};
        `LCSL_ADDR_IRQ_MASK: o_rdata <= {30'h0, irq_mask};
        `LCSL_ADDR_WORDS:    o_rdata <= {24'h0, ndev};
        default:             o_rdata <= 32'h0000_0000;
      endcase
    end else o_rdata <= 32'h0000_0000;
  end
endmodule : lcsl_host
`default_nettype wire

// File: test/lcsl_link_sva.sv
// assertions on the led link wires and the driver's channel outputs
`timescale 1ns/1ps
`default_nettype none
module lcsl_link_sva (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic sclk,
  input wire logic sdata_in,
  input wire logic sdata_out,
  input wire logic latch_load,
  input wire logic gate_n,
  input wire logic o_channel1_sink,
  input wire logic o_channel2_sink,
  input wire logic o_channel3_sink,
  input wire logic o_thermal_off
);
  logic [2:0] sr_m;
  logic [2:0] lat_m;
  logic [7:0] rises;
  wire  [2:0] sinks = {o_channel3_sink, o_channel2_sink, o_channel1_sink};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // reference shift stages and latch, ahead of the driver's sampler lag
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sr_m  <= 3'h0;
      lat_m <= 3'h0;
    end else begin
      if ($rose(sclk))
        sr_m <= {sr_m[1:0], sdata_in};
      if (latch_load)
        lat_m <= sr_m;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst)
      rises <= 8'h00;
    else if ($fell(latch_load))
      rises <= 8'h00;
    else if ($rose(sclk))
      rises <= rises + 8'h01;
  end
  AST_SHIFT: assert property ($rose(sclk) |-> ##8 (sdata_out == sr_m[2]))
    else $error("serial out differs from third stage");
  AST_DIN: assert property ($rose(sclk) |-> $stable(sdata_in) [*5])
    else $error("serial data moved near clock rise");
  AST_COUNT: assert property ($rose(latch_load) |-> (rises % 8'd3) == 8'd0)
    else $error("latch raised after partial word");
  AST_TRANS: assert property ((latch_load && !gate_n && !o_thermal_off && !$rose(sclk)) [*8]
    |-> sinks == sr_m)
    else $error("transparent latch not following shift stages");
  AST_HOLD: assert property ((!latch_load && !gate_n && !o_thermal_off) [*8] |-> $stable(sinks))
    else $error("closed latch changed");
  AST_FOLLOW: assert property ((!latch_load && !gate_n && !o_thermal_off) [*8] |-> sinks == lat_m)
    else $error("channels differ from latched word");
  AST_GATE: assert property (gate_n [*6] |-> sinks == 3'h0)
    else $error("channel on while gate closed");
  AST_THERM: assert property (o_thermal_off [*2] |-> sinks == 3'h0)
    else $error("channel on in shutdown");
  cover property ($rose(latch_load));
  cover property ($rose(o_thermal_off));
  cover property (latch_load && !gate_n && $rose(sclk));
endmodule : lcsl_link_sva
`default_nettype wire

// File: test/testbench.sv
// self-checking bench joining the host and driver ends of the led link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_clk_sys;
  logic        i_nrst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [2:0]  dim;
  logic        over;
  logic        cool;
  logic        therm;
  logic [31:0] rdata;
  logic        irq;
  logic [2:0]  sinks;
  logic [2:0]  psinks;
  logic [31:0] d;
  int          fails;
  int          compares;
  bit          shift_q[$];
  int          model_latch;
  int          model_gate_n;
  int          model_off;
  lcsl_link_if link ();
  lcsl_link_if plink ();
  // parallel variant ignores the serial side
  assign plink.sclk = 1'b0;
  assign plink.sdata_in = 1'b0;
  assign plink.latch_load = 1'b0;
  assign plink.gate_n = 1'b0;
  lcsl_host i_lcsl_host (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(link), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .i_thermal_off(therm), .o_rdata(rdata), .o_irq(irq));
  lcsl_driver i_lcsl_driver (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(link), .i_channel1_dim_in(dim[0]),
    .i_channel2_dim_in(dim[1]), .i_channel3_dim_in(dim[2]), .i_temp_over(over), .i_temp_cool(cool),
    .o_channel1_sink(sinks[0]), .o_channel2_sink(sinks[1]), .o_channel3_sink(sinks[2]), .o_thermal_off(therm));
  lcsl_driver #(.PARALLEL_VARIANT(1'b1)) i_lcsl_driver_par (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(plink),
    .i_channel1_dim_in(dim[0]), .i_channel2_dim_in(dim[1]), .i_channel3_dim_in(dim[2]), .i_temp_over(over),
    .i_temp_cool(cool), .o_channel1_sink(psinks[0]), .o_channel2_sink(psinks[1]), .o_channel3_sink(psinks[2]),
    .o_thermal_off());
  lcsl_link_sva i_lcsl_link_sva (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .sclk(link.sclk),
    .sdata_in(link.sdata_in), .sdata_out(link.sdata_out), .latch_load(link.latch_load), .gate_n(link.gate_n),
    .o_channel1_sink(sinks[0]), .o_channel2_sink(sinks[1]), .o_channel3_sink(sinks[2]), .o_thermal_off(therm));
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // behavioural model: shift stages in a queue, latch, gate and shutdown as integers
  function automatic int model_stage();
    int sr;
    sr = 0;
    foreach (shift_q[k]) sr = ((sr << 1) | int'(shift_q[k])) & 7;
    return sr;
  endfunction : model_stage
  function automatic int model_sinks();
    if (model_off != 0 || model_gate_n != 0) return 0;
    return model_latch;
  endfunction : model_sinks
  task automatic check_sinks(input string name, input int exp, input logic [2:0] got);
    check(name, 32'(exp), {29'h0, got});
  endtask : check_sinks
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge i_clk_sys);
    wr_s <= 1'b0;
    @(posedge i_clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge i_clk_sys);
    rd_s <= 1'b0;
    #1 v = rdata;
    @(posedge i_clk_sys);
  endtask : rd
  task automatic settle();
    repeat (10) @(posedge i_clk_sys);
  endtask : settle
  // word out msb first, then latch pulse; expected channels from the word
  task automatic send(input logic [2:0] w, input logic gate_n, input logic hold);
    wr(4'h1, {29'h0, w});
    wr(4'h0, {29'h0, hold, gate_n, 1'b1});
    d = 32'h0000_0001;
    for (int n = 0; n < 300 && d[0] === 1'b1; n++)
      rd(4'h2, d);
    check("busy", 32'h0, {31'h0, d[0]});
    settle();
    for (int b = 2; b >= 0; b--) shift_q.push_back(w[b]);
    while (shift_q.size() > 3) void'(shift_q.pop_front());
    model_latch = model_stage();
    model_gate_n = int'(gate_n);
    check_sinks("sinks", model_sinks(), sinks);
  endtask : send
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    {addr, wdata, wr_s, rd_s, dim, over, cool} = '0;
    i_nrst = 1'b0;
    fails = 0;
    compares = 0;
    model_latch = 0;
    model_gate_n = 1;
    model_off = 0;
    void'($urandom(32'h0000_b829));
    repeat (10) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    rd(4'h5, d);
    check("count", 32'h1, d);
    rd(4'hf, d);
    check("unmapped", 32'h0, d);
    wr(4'h4, 32'h1);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      send(d[2:0], d[3], 1'b0);
      check("irq", 32'h1, {31'h0, irq});
      wr(4'h3, 32'h1);
      settle();
      check("irq", 32'h0, {31'h0, irq});
    end
    wr(4'h4, 32'h0);
    send(3'h5, 1'b1, 1'b0);
    check("irq", 32'h0, {31'h0, irq});
    rd(4'h3, d);
    check("irq_stat", 32'h1, d);
    wr(4'h0, 32'h0);
    settle();
    model_gate_n = 0;
    check_sinks("sinks", model_sinks(), sinks);
    send(3'h6, 1'b0, 1'b1);
    over <= 1'b1;
    settle();
    model_off = 1;
    check_sinks("sinks", model_sinks(), sinks);
    rd(4'h2, d);
    check("status", 32'h2, d);
    over <= 1'b0;
    settle();
    check_sinks("sinks", model_sinks(), sinks);
    cool <= 1'b1;
    settle();
    model_off = 0;
    check_sinks("sinks", model_sinks(), sinks);
    cool <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      dim <= d[2:0];
      settle();
      check_sinks("dim", int'(d[2:0]), psinks);
    end
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    fails++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
